/* verilog/sbu_pkg.sv */
`default_nettype none
package sbu_pkg;
  // ----------------------------------------
  // Word and field geometry
  // ----------------------------------------
  localparam int WORD_W = 60;
  localparam int COUNT_W = 18;
  localparam int PARCEL_W = 15;
  localparam int OPC_W = 6;
  localparam int DES_W = 3;
  localparam int OPC_LSB = 9;
  localparam int DES_I_LSB = 6;
  localparam int DES_J_LSB = 3;
  localparam int DES_K_LSB = 0;
  localparam int CNT_SIGN_BIT = 17;
  localparam int CNT_RANGE_LSB = 6;
  localparam int CNT_RANGE_MSB = 10;
  localparam logic [6:0] WORD_BITS = 7'h3c;

  // ----------------------------------------
  // Opcodes (octal 21, 23, 12, 16, 13, 17, 11, 15)
  // ----------------------------------------
  localparam logic [OPC_W-1:0] OPC_ASR_FIXED = 6'h11;
  localparam logic [OPC_W-1:0] OPC_ASR_VAR = 6'h13;
  localparam logic [OPC_W-1:0] OPC_OR = 6'h0a;
  localparam logic [OPC_W-1:0] OPC_OR_NOT = 6'h0e;
  localparam logic [OPC_W-1:0] OPC_XOR = 6'h0b;
  localparam logic [OPC_W-1:0] OPC_XNOR = 6'h0f;
  localparam logic [OPC_W-1:0] OPC_AND = 6'h09;
  localparam logic [OPC_W-1:0] OPC_AND_NOT = 6'h0d;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [WORD_W-1:0] WORD_RST = 60'h000000000000000;
  localparam logic [DES_W-1:0] DES_RST = 3'h0;
  localparam logic [OPC_W-1:0] OPC_RST = 6'h00;

  typedef enum logic [3:0] {
    SBU_IDLE = 4'h1,
    SBU_READ = 4'h2,
    SBU_EXEC = 4'h4,
    SBU_WRITE = 4'h8
  } sbu_state_type;
endpackage
`default_nettype wire

/* verilog/sbu_op_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface sbu_op_if;
  import sbu_pkg::*;
  logic [OPC_W-1:0] opcode;
  logic [WORD_W-1:0] src_first;
  logic [WORD_W-1:0] src_second;
  logic [COUNT_W-1:0] count;
  logic [5:0] fixed_count;
  logic [WORD_W-1:0] result;
  logic known;
  modport ctrl (output opcode, src_first, src_second, count, fixed_count, input result, known);
  modport unit (input opcode, src_first, src_second, count, fixed_count, output result, known);
endinterface
`default_nettype wire

/* verilog/sbu_exec.sv */
`timescale 1ns/1ns
`default_nettype none
module sbu_exec
  import sbu_pkg::*;
(
  sbu_op_if.unit op
);
  // ----------------------------------------
  // Shift helpers
  // ----------------------------------------
  // Arithmetic right shift; counts past the word give all sign bits
  function automatic logic [WORD_W-1:0] asr(input logic [WORD_W-1:0] v, input logic [5:0] n);
    asr = $signed(v) >>> n;
  endfunction

  // Circular left rotate, count taken modulo the word length
  function automatic logic [WORD_W-1:0] rotl(input logic [WORD_W-1:0] v, input logic [5:0] n);
    logic [6:0] m;
    logic [2*WORD_W-1:0] dbl;
    m = {1'b0, n};
    if (m >= WORD_BITS) begin
      m = 7'(m - WORD_BITS);
    end
    dbl = {v, v} << m;
    rotl = dbl[2*WORD_W-1:WORD_W];
  endfunction

  // ----------------------------------------
  // Operation select
  // ----------------------------------------
  // Bits 11..16 of the count are never looked at
  logic cnt_neg;
  logic cnt_far;
  assign cnt_neg = op.count[CNT_SIGN_BIT];
  assign cnt_far = (op.count[CNT_RANGE_MSB:CNT_RANGE_LSB] != 5'h00);

  always_comb begin
    op.known = 1'b1;
    op.result = WORD_RST;
    unique case (op.opcode)
      OPC_ASR_FIXED: op.result = asr(op.src_first, op.fixed_count);
      OPC_ASR_VAR: begin
        if (cnt_neg) begin
          op.result = rotl(op.src_second, ~op.count[5:0]);
        end else if (cnt_far) begin
          op.result = WORD_RST;
        end else begin
          op.result = asr(op.src_second, op.count[5:0]);
        end
      end
      OPC_OR: op.result = op.src_first | op.src_second;
      OPC_OR_NOT: op.result = op.src_first | ~op.src_second;
      OPC_XOR: op.result = op.src_first ^ op.src_second;
      OPC_XNOR: op.result = op.src_first ^ ~op.src_second;
      OPC_AND: op.result = op.src_first & op.src_second;
      OPC_AND_NOT: op.result = op.src_first & ~op.src_second;
      default: op.known = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* verilog/sbu_top.sv */
`timescale 1ns/1ns
`default_nettype none
module sbu_top
  import sbu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_issue_valid,
  input wire logic [PARCEL_W-1:0] i_parcel,
  output logic o_issue_ready,
  output logic o_rd_en,
  output logic [DES_W-1:0] o_rd_first_addr,
  output logic [DES_W-1:0] o_rd_second_addr,
  output logic [DES_W-1:0] o_rd_count_addr,
  input wire logic [WORD_W-1:0] i_first_data,
  input wire logic [WORD_W-1:0] i_second_data,
  input wire logic [COUNT_W-1:0] i_count_data,
  output logic o_wr_en,
  output logic [DES_W-1:0] o_wr_addr,
  output logic [WORD_W-1:0] o_wr_data,
  output logic o_bad_opcode
);
  // ----------------------------------------
  // Parcel decode
  // ----------------------------------------
  // Fields of the parcel on offer
  logic [OPC_W-1:0] dec_opc;
  logic [DES_W-1:0] dec_i;
  logic [DES_W-1:0] dec_j;
  logic [DES_W-1:0] dec_k;
  logic dec_ok;
  logic accept;
  // Sequencer state
  sbu_state_type state_reg;
  sbu_state_type state_next;
  // Operation held for its whole run
  logic [OPC_W-1:0] opc_reg;
  logic [DES_W-1:0] dest_reg;
  logic [5:0] fixed_reg;
  // Carrier to the execute stage
  sbu_op_if op ();

  // Only the shift and logical opcodes belong to this unit
  function automatic logic opc_supported(input logic [OPC_W-1:0] opc);
    opc_supported = (opc == OPC_ASR_FIXED) || (opc == OPC_ASR_VAR) || (opc == OPC_OR) ||
                    (opc == OPC_OR_NOT) || (opc == OPC_XOR) || (opc == OPC_XNOR) ||
                    (opc == OPC_AND) || (opc == OPC_AND_NOT);
  endfunction

  // Field slicing
  assign dec_opc = i_parcel[OPC_LSB +: OPC_W];
  assign dec_i = i_parcel[DES_I_LSB +: DES_W];
  assign dec_j = i_parcel[DES_J_LSB +: DES_W];
  assign dec_k = i_parcel[DES_K_LSB +: DES_W];
  assign dec_ok = opc_supported(dec_opc);
  assign accept = i_issue_valid && (state_reg == SBU_IDLE);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Timeline of one supported operation, in cycles after the issue edge:
  //   1: read strobe and addresses out
  //   2: operand words present, result computed and captured
  //   3: write strobe, destination and result out
  //   4: ready again
  // Ready drops on the issue edge itself, so a second parcel is never taken early
  // One operation at a time; no overlap keeps the write-back ordering trivial
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SBU_IDLE: begin
        if (accept && dec_ok) begin
          state_next = SBU_READ;
        end
      end
      SBU_READ: state_next = SBU_EXEC;
      SBU_EXEC: state_next = SBU_WRITE;
      SBU_WRITE: state_next = SBU_IDLE;
      default: state_next = SBU_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state_reg <= SBU_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Ready follows the next state so it is a clean flop output
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_issue_ready <= 1'b0;
    end else begin
      o_issue_ready <= (state_next == SBU_IDLE);
    end
  end

  // ----------------------------------------
  // Operand read request
  // ----------------------------------------
  // Read strobe, one cycle per accepted supported parcel
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_rd_en <= 1'b0;
    end else begin
      o_rd_en <= accept && dec_ok;
    end
  end

  // First source; fixed shift reads i itself, others read j
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_rd_first_addr <= DES_RST;
    end else if (accept && dec_ok) begin
      o_rd_first_addr <= (dec_opc == OPC_ASR_FIXED) ? dec_i : dec_j;
    end
  end

  // Second source and count addresses stand until the next supported parcel is accepted
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_rd_second_addr <= DES_RST;
      o_rd_count_addr <= DES_RST;
    end else if (accept && dec_ok) begin
      o_rd_second_addr <= dec_k;
      o_rd_count_addr <= dec_j;
    end
  end

  // ----------------------------------------
  // Operation latch
  // ----------------------------------------
  // Opcode and destination kept, since the parcel may change right after issue
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      opc_reg <= OPC_RST;
      dest_reg <= DES_RST;
    end else if (accept && dec_ok) begin
      opc_reg <= dec_opc;
      dest_reg <= dec_i;
    end
  end

  // Fixed count is known at issue; the variable count comes with the read data
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      fixed_reg <= 6'h00;
    end else if (accept && dec_ok) begin
      fixed_reg <= {dec_j, dec_k};
    end
  end

  // A refused parcel leaves the sequencer idle, so the next may follow at once
  // Unsupported opcodes are flagged and dropped, never executed
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_bad_opcode <= 1'b0;
    end else begin
      o_bad_opcode <= accept && !dec_ok;
    end
  end

  // ----------------------------------------
  // Execute and write back
  // ----------------------------------------
  assign op.opcode = opc_reg;
  assign op.src_first = i_first_data;
  assign op.src_second = i_second_data;
  assign op.count = i_count_data;
  assign op.fixed_count = fixed_reg;

  sbu_exec u_exec (
    .op(op)
  );

  // Write strobe only for an opcode the execute stage recognised
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_wr_en <= 1'b0;
    end else begin
      o_wr_en <= (state_reg == SBU_EXEC) && op.known;
    end
  end

  // Result is captured while read data is present, written next cycle
  // Address and data then stand until the next write
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_wr_addr <= DES_RST;
      o_wr_data <= WORD_RST;
    end else if (state_reg == SBU_EXEC) begin
      o_wr_addr <= dest_reg;
      o_wr_data <= op.result;
    end
  end
endmodule
`default_nettype wire

/* tb/sbu_top_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// --
// Issue and result checks
// --
module sbu_top_asserts
  import sbu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_issue_valid,
  input wire logic [PARCEL_W-1:0] i_parcel,
  input wire logic o_issue_ready,
  input wire logic o_rd_en,
  input wire logic [DES_W-1:0] o_rd_first_addr,
  input wire logic [DES_W-1:0] o_rd_second_addr,
  input wire logic [DES_W-1:0] o_rd_count_addr,
  input wire logic [WORD_W-1:0] i_first_data,
  input wire logic [WORD_W-1:0] i_second_data,
  input wire logic [COUNT_W-1:0] i_count_data,
  input wire logic o_wr_en,
  input wire logic [DES_W-1:0] o_wr_addr,
  input wire logic [WORD_W-1:0] o_wr_data,
  input wire logic o_bad_opcode
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // Opcode of the parcel on offer
  wire logic [OPC_W-1:0] opc = i_parcel[OPC_LSB+:OPC_W];
  a_issue_answered: assert property (i_issue_valid && o_issue_ready |=> o_rd_en || o_bad_opcode)
    else $error("issue not answered");
  a_busy_window: assert property (o_rd_en |-> !o_issue_ready [*3] ##1 o_issue_ready)
    else $error("busy window wrong");
  a_write_timing: assert property (o_rd_en |-> ##2 o_wr_en)
    else $error("write back not in time");
  a_bad_quiet: assert property (o_bad_opcode |-> !o_rd_en ##2 !o_wr_en)
    else $error("bad opcode not quiet");
  a_wr_dest: assert property (o_wr_en |-> o_wr_addr == $past(i_parcel[DES_I_LSB+:DES_W], 3))
    else $error("wrong destination");
  a_src_addr: assert property (o_rd_en |-> o_rd_second_addr == $past(i_parcel[2:0])
    && o_rd_count_addr == $past(i_parcel[5:3]))
    else $error("wrong source address");
  a_first_addr: assert property (o_rd_en |-> o_rd_first_addr ==
    ($past(opc) == OPC_ASR_FIXED ? $past(i_parcel[8:6]) : $past(i_parcel[5:3])))
    else $error("wrong first address");
  a_and_data: assert property (o_wr_en && $past(opc, 3) == OPC_AND |->
    o_wr_data == ($past(i_first_data) & $past(i_second_data)))
    else $error("and result wrong");
  a_rotate_ones: assert property (o_wr_en && $past(opc, 3) == OPC_ASR_VAR && $past(i_count_data[17]) |->
    $countones(o_wr_data) == $countones($past(i_second_data)))
    else $error("rotate lost bits");
endmodule
bind sbu_top sbu_top_asserts u_chk (.*);
`default_nettype wire

/* tb/sbu_rf_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sbu_rf_model
  import sbu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic o_rd_en,
  input wire logic [DES_W-1:0] o_rd_first_addr,
  input wire logic [DES_W-1:0] o_rd_second_addr,
  input wire logic [DES_W-1:0] o_rd_count_addr,
  input wire logic o_wr_en,
  input wire logic [DES_W-1:0] o_wr_addr,
  input wire logic [WORD_W-1:0] o_wr_data,
  output logic [WORD_W-1:0] i_first_data = '0,
  output logic [WORD_W-1:0] i_second_data = '0,
  output logic [COUNT_W-1:0] i_count_data = '0
);
  logic [WORD_W-1:0] xr [8];
  logic [COUNT_W-1:0] br [8];
  // Data valid only the cycle after a read; else it toggles so stale sampling shows
  always @(posedge i_clk_sys) begin
    i_first_data <= o_rd_en ? xr[o_rd_first_addr] : ~i_first_data;
    i_second_data <= o_rd_en ? xr[o_rd_second_addr] : ~i_second_data;
    i_count_data <= o_rd_en ? br[o_rd_count_addr] : ~i_count_data;
    if (o_wr_en) xr[o_wr_addr] <= o_wr_data;
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sbu_pkg::*;
  logic i_clk_sys = 0, i_sys_rst = 1, i_issue_valid = 0, o_issue_ready, o_rd_en, o_wr_en, o_bad_opcode;
  logic [PARCEL_W-1:0] i_parcel = '0;
  logic [DES_W-1:0] o_rd_first_addr, o_rd_second_addr, o_rd_count_addr, o_wr_addr;
  logic [WORD_W-1:0] i_first_data, i_second_data, o_wr_data;
  logic [COUNT_W-1:0] i_count_data;
  int error_cnt = 0, checks_done = 0;
  localparam logic [5:0] OPS [8] = '{OPC_ASR_FIXED, OPC_ASR_VAR, OPC_OR, OPC_OR_NOT, OPC_XOR, OPC_XNOR,
    OPC_AND, OPC_AND_NOT};
  localparam logic [17:0] CNT [6] = '{18'h3fff5, 18'h1f806, 18'h00046, 18'h3ffc0, 18'h3ffff, 18'h0003f};
  always #10 i_clk_sys = ~i_clk_sys;
  sbu_top dut (.*);
  sbu_rf_model rf (.*);
  // Reference result, worked out from the operation definitions
  function automatic logic [59:0] f(logic [5:0] op, logic [59:0] a, b, logic [17:0] c, logic [5:0] n);
    logic signed [59:0] sa, sb;
    int m;
    begin
      sa = a;
      sb = b;
      m = int'(6'(~c[5:0])) % 60;
      case (op)
        OPC_ASR_FIXED: return sa >>> n;
        OPC_ASR_VAR: if (c[17]) return (b << m) | (b >> (60 - m));
          else if (c[10:6] != 0) return '0;
          else return sb >>> c[5:0];
        OPC_OR: return a | b;
        OPC_OR_NOT: return a | ~b;
        OPC_XOR: return a ^ b;
        OPC_XNOR: return a ^ ~b;
        OPC_AND: return a & b;
        default: return a & ~b;
      endcase
    end
  endfunction
  task automatic chk(string s, logic [59:0] e, g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic fill(int r);
    rf.xr[r] = 60'({$urandom, $urandom});
    rf.br[r] = 18'($urandom);
    if ($urandom % 2) rf.br[r][10:6] = {5{rf.br[r][17]}};
  endtask
  // One issue, then wait for the write-back or the refusal flag
  task automatic run(input logic [5:0] op, input logic [2:0] i, j, k);
    logic [59:0] e;
    int n;
    begin
      for (n = 0; n < 9 && o_issue_ready !== 1'b1; n++) @(posedge i_clk_sys) #1;
      if (n == 9) begin
        chk("ready", 1, 0);
        results;
      end
      // Worked out only once the last write-back has landed in the model
      e = f(op, rf.xr[op == OPC_ASR_FIXED ? i : j], rf.xr[k], rf.br[j], {j, k});
      @(posedge i_clk_sys);
      i_issue_valid <= 1;
      i_parcel <= {op, i, j, k};
      @(posedge i_clk_sys);
      i_issue_valid <= 0;
      #1;
      for (n = 0; n < 9 && o_wr_en !== 1'b1 && o_bad_opcode !== 1'b1; n++) @(posedge i_clk_sys) #1;
      if (n == 9) begin
        chk("done", 1, 0);
        results;
      end
      if (op inside {OPS}) begin
        chk("addr", i, o_wr_addr);
        chk("data", e, o_wr_data);
      end else begin
        chk("bad", 1, o_bad_opcode);
        chk("wr", 0, o_wr_en);
      end
    end
  endtask
  // Corner cases first, then random traffic
  initial begin
    void'($urandom(32'hf731826d));
    for (int r = 0; r < 8; r++) fill(r);
    repeat (20) @(posedge i_clk_sys);
    i_sys_rst <= 0;
    foreach (CNT[c]) begin
      rf.br[3] = CNT[c];
      run(OPC_ASR_VAR, 4, 3, 5);
    end
    run(OPC_ASR_FIXED, 2, 7, 7);
    run(OPC_ASR_FIXED, 2, 7, 4);
    run(6'h14, 1, 2, 3);
    $display("test corners done");
    repeat (300) begin
      fill($urandom % 8);
      run(OPS[$urandom % 8], 3'($urandom), 3'($urandom), 3'($urandom));
    end
    $display("test random done");
    results;
  end
endmodule
`default_nettype wire
